// *** src/scs_pkg.sv ***
// shared constants and decode functions for the system clock select and gating block
package scs_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MCLK_HZ = 25_000_000;
    localparam int STRAP_SETTLE_NS = 120;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_CNT_W = 4;

    // ----------------------------------------
    // synthesized clock model
    // ----------------------------------------
    // rates are kept in 10 kHz units; the model clock runs at rate / SYNTH_SCALE
    localparam int RATE_UNIT_HZ = 10_000;
    localparam int MCLK_RATE_UNITS = MCLK_HZ / RATE_UNIT_HZ;
    localparam int SYNTH_SCALE = 16;
    localparam int ACC_W = 16;
    localparam logic [ACC_W-1:0] HALF_ACC = ACC_W'(MCLK_RATE_UNITS * SYNTH_SCALE / 2);
    localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;

    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int CODE_W = 4;
    localparam int CPU_GATED_N = 3;
    localparam int MEM_GATED_N = 12;
    localparam int PERIPH_GATED_N = 5;
    localparam int FREE_N = 3;
    localparam int FREE_CPU = 0;
    localparam int FREE_MEM = 1;
    localparam int FREE_PERIPH = 2;
    localparam int SYNC_N = 10;
    localparam int SY_FS0 = 0;
    localparam int SY_FS1 = 1;
    localparam int SY_FS2 = 2;
    localparam int SY_FS3 = 3;
    localparam int SY_MODE = 4;
    localparam int SY_PSTOP = 5;
    localparam int SY_CSTOP = 6;
    localparam int SY_BUF = 7;
    localparam int SY_XTAL = 8;
    localparam int SY_USB = 9;
    localparam logic [CODE_W-1:0] CODE_RST = 4'hf;
    localparam logic [1:0] DIV_TWO = 2'h2;
    localparam logic [1:0] DIV_THREE = 2'h3;

    typedef enum logic {
        SCS_STRAP,
        SCS_RUN
    } scs_phase_t;

    // processor rate for a select code, 10 kHz units
    function automatic logic [ACC_W-1:0] scs_cpu_rate(input logic [CODE_W-1:0] code);
        case (code)
            4'hf: scs_cpu_rate = 16'd6000;
            4'he: scs_cpu_rate = 16'd6680;
            4'hd: scs_cpu_rate = 16'd7000;
            4'hc: scs_cpu_rate = 16'd9000;
            4'hb: scs_cpu_rate = 16'd8000;
            4'ha: scs_cpu_rate = 16'd8330;
            4'h9: scs_cpu_rate = 16'd9525;
            4'h8: scs_cpu_rate = 16'd10020;
            4'h7: scs_cpu_rate = 16'd7500;
            4'h6: scs_cpu_rate = 16'd8000;
            4'h5: scs_cpu_rate = 16'd8330;
            4'h4: scs_cpu_rate = 16'd10500;
            4'h3: scs_cpu_rate = 16'd11000;
            4'h2: scs_cpu_rate = 16'd11500;
            4'h1: scs_cpu_rate = 16'd12000;
            default: scs_cpu_rate = 16'd12400;
        endcase
    endfunction

    // peripheral divide ratio for a select code
    function automatic logic [1:0] scs_periph_div(input logic [CODE_W-1:0] code);
        case (code)
            4'hf, 4'he, 4'hd, 4'h7, 4'h6, 4'h5: scs_periph_div = DIV_TWO;
            default: scs_periph_div = DIV_THREE;
        endcase
    endfunction

endpackage

// *** src/scs_clk_synth.sv ***
// processor clock synthesizer model with peripheral divider
`timescale 1ns/1ps
`default_nettype none
module scs_clk_synth
    import scs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [CODE_W-1:0] code,
    output logic cpu_clk,
    output logic cpu_fall,
    output logic periph_clk,
    output logic periph_rise,
    output logic periph_fall
);

    logic [ACC_W-1:0] acc_r, acc_nxt;
    logic [ACC_W-1:0] inc_r, inc_nxt;
    logic cpu_r, cpu_nxt;
    logic [1:0] ratio_r, ratio_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic per_r, per_nxt;
    logic [ACC_W-1:0] sum;
    logic toggle;
    logic cpu_rise;

    always_comb begin
        sum = acc_r + inc_r;
        toggle = run && (sum >= HALF_ACC);
        acc_nxt = run ? (toggle ? sum - HALF_ACC : sum) : ACC_RST;
        cpu_nxt = toggle ? ~cpu_r : cpu_r;
        // new rate only at a phase boundary, so no phase is cut short
        inc_nxt = (toggle || !run) ? scs_cpu_rate(code) : inc_r;
        cpu_rise = toggle && !cpu_r;
        cpu_fall = toggle && cpu_r;
        cnt_nxt = cnt_r;
        ratio_nxt = ratio_r;
        if (cpu_rise) begin
            if (cnt_r >= ratio_r - 2'h1) begin
                cnt_nxt = 2'h0;
                ratio_nxt = scs_periph_div(code);
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
        per_nxt = cpu_rise ? (cnt_nxt == 2'h0) : per_r;
        periph_rise = per_nxt && !per_r;
        periph_fall = !per_nxt && per_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_r <= ACC_RST;
            inc_r <= scs_cpu_rate(CODE_RST);
            cpu_r <= 1'b0;
            ratio_r <= DIV_TWO;
            cnt_r <= 2'h0;
            per_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            inc_r <= inc_nxt;
            cpu_r <= cpu_nxt;
            ratio_r <= ratio_nxt;
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
        end
    end

    assign cpu_clk = cpu_r;
    assign periph_clk = per_r;

endmodule
`default_nettype wire

// *** src/scs_top.sv ***
// clock select, strap latching and output gating top level
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - straps are sampled once after reset and held as the hardware frequency code
// - each of sixteen codes maps to one fixed processor rate
// - peripheral clock is processor divided by two or three per code
// - processor rate changes cleanly across the full selectable range
// - free processor clock keeps toggling whatever the processor stop level
// - gated processor clocks go low while processor stop is low
// - processor stop is asynchronous and also halts gated memory clocks low
// - free memory clock keeps toggling regardless of processor stop
// - memory clocks are a fanout copy of the buffer input
// - free peripheral clock runs normally; its pin also latches the mode strap
// - mode one makes the shared pin a reference output, mode zero a stop input
// - in mode zero, peripheral stop low holds five gated peripheral clocks low
// - reference outputs run at crystal rate; first one is the strong drive
// - after latching, strap pins carry second reference, 24 MHz and 48 MHz
// - four processor, thirteen memory and six peripheral clocks are provided
// - each processor, memory and peripheral clock has its own enable; all outputs may be tri-stated
// - processor and peripheral gates change after free peripheral rise then falling edge of that clock
// - a gated clock runs only when its enable and its stop input both allow
module scs_top
    import scs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_stop_n,
    input wire logic buffer_in,
    input wire logic xtal_ref_in,
    input wire logic usb_48_in,
    input wire logic [CPU_GATED_N-1:0] cpu_en,
    input wire logic [MEM_GATED_N-1:0] mem_en,
    input wire logic [PERIPH_GATED_N-1:0] periph_en,
    input wire logic [FREE_N-1:0] free_en,
    input wire logic outputs_tristate,
    input wire logic sw_sel_en,
    input wire logic [CODE_W-1:0] sw_sel_code,
    input wire logic freq_strap_3_in,
    input wire logic freq_strap_2_in,
    input wire logic freq_strap_1_in,
    input wire logic freq_strap_0_in,
    input wire logic mode_strap_in,
    input wire logic periph_stop_n_in,
    output logic cpu_clk_free,
    output logic [CPU_GATED_N-1:0] cpu_clk_gated,
    output logic mem_clk_free,
    output logic [MEM_GATED_N-1:0] mem_clk_gated,
    output logic [PERIPH_GATED_N-2:0] periph_clk_gated,
    output logic clk_oe_n,
    output logic periph_clk_first,
    output logic periph_clk_first_oe_n,
    output logic periph_clk_free,
    output logic periph_clk_free_oe_n,
    output logic xtal_ref_out_a,
    output logic xtal_ref_out_a_oe_n,
    output logic xtal_ref_out_b,
    output logic xtal_ref_out_b_oe_n,
    output logic clk_24_out,
    output logic clk_24_oe_n,
    output logic usb_48_out,
    output logic usb_48_oe_n,
    output logic [CODE_W-1:0] active_code,
    output logic mode_latched,
    output logic straps_done
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [SYNC_N-1:0] sync1_r, sync2_r;
    logic [SYNC_N-1:0] pins;

    always_comb begin
        pins = '0;
        pins[SY_FS0] = freq_strap_0_in;
        pins[SY_FS1] = freq_strap_1_in;
        pins[SY_FS2] = freq_strap_2_in;
        pins[SY_FS3] = freq_strap_3_in;
        pins[SY_MODE] = mode_strap_in;
        pins[SY_PSTOP] = periph_stop_n_in;
        pins[SY_CSTOP] = cpu_stop_n;
        pins[SY_BUF] = buffer_in;
        pins[SY_XTAL] = xtal_ref_in;
        pins[SY_USB] = usb_48_in;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    // ----------------------------------------
    // strap latching
    // ----------------------------------------
    scs_phase_t phase_r, phase_nxt;
    logic [STRAP_CNT_W-1:0] settle_r, settle_nxt;
    logic [CODE_W-1:0] strap_code_r, strap_code_nxt;
    logic mode_r, mode_nxt;

    always_comb begin
        phase_nxt = phase_r;
        settle_nxt = settle_r;
        strap_code_nxt = strap_code_r;
        mode_nxt = mode_r;
        case (phase_r)
            SCS_STRAP: begin
                // pins are released until the synchronised strap levels settle
                if (settle_r == STRAP_CNT_W'(STRAP_SETTLE_CYC)) begin
                    strap_code_nxt = {sync2_r[SY_FS3], sync2_r[SY_FS2],
                                      sync2_r[SY_FS1], sync2_r[SY_FS0]};
                    mode_nxt = sync2_r[SY_MODE];
                    phase_nxt = SCS_RUN;
                end else begin
                    settle_nxt = settle_r + 1'b1;
                end
            end
            SCS_RUN: begin
                phase_nxt = SCS_RUN;
            end
            default: begin
                phase_nxt = SCS_STRAP;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_r <= SCS_STRAP;
            settle_r <= '0;
            strap_code_r <= CODE_RST;
            mode_r <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            settle_r <= settle_nxt;
            strap_code_r <= strap_code_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ----------------------------------------
    // frequency synthesis
    // ----------------------------------------
    logic running;
    logic [CODE_W-1:0] sel_code;
    logic cpu_clk, cpu_fall, per_clk, per_rise, per_fall;

    assign running = (phase_r == SCS_RUN);
    assign sel_code = sw_sel_en ? sw_sel_code : strap_code_r;

    scs_clk_synth u_synth (
        .mclk(mclk),
        .rst(rst),
        .run(running),
        .code(sel_code),
        .cpu_clk(cpu_clk),
        .cpu_fall(cpu_fall),
        .periph_clk(per_clk),
        .periph_rise(per_rise),
        .periph_fall(per_fall)
    );

    // ----------------------------------------
    // stop gating
    // ----------------------------------------
    logic cpu_ok, per_ok, mem_buf_r, mem_fall, x48_r, x48_rise;
    logic arm_cpu_r, arm_cpu_nxt, arm_per_r, arm_per_nxt;
    logic [CPU_GATED_N-1:0] cpu_gate_r, cpu_gate_nxt;
    logic [MEM_GATED_N-1:0] mem_gate_r, mem_gate_nxt;
    logic [PERIPH_GATED_N-1:0] per_gate_r, per_gate_nxt;
    logic [FREE_N-1:0] free_gate_r, free_gate_nxt;
    logic [FREE_N-1:0] free_fall;
    logic c24_r, c24_nxt;

    always_comb begin
        cpu_ok = sync2_r[SY_CSTOP];
        per_ok = mode_r || sync2_r[SY_PSTOP];
        mem_fall = mem_buf_r && !sync2_r[SY_BUF];
        x48_rise = sync2_r[SY_USB] && !x48_r;
        free_fall = '0;
        free_fall[FREE_CPU] = cpu_fall;
        free_fall[FREE_MEM] = mem_fall;
        free_fall[FREE_PERIPH] = per_fall;
        // an arm and an apply in one cycle keep the arm for the next fall
        arm_cpu_nxt = per_rise || (arm_cpu_r && !cpu_fall);
        arm_per_nxt = per_rise || (arm_per_r && !per_fall);
        cpu_gate_nxt = (arm_cpu_r && cpu_fall) ? (cpu_en & {CPU_GATED_N{cpu_ok}}) : cpu_gate_r;
        per_gate_nxt = (arm_per_r && per_fall) ? (periph_en & {PERIPH_GATED_N{per_ok}}) : per_gate_r;
        mem_gate_nxt = mem_fall ? (mem_en & {MEM_GATED_N{cpu_ok}}) : mem_gate_r;
        // free outputs follow only their enables, never a stop input
        free_gate_nxt = free_gate_r;
        for (int i = 0; i < FREE_N; i++) begin
            if (free_fall[i]) begin
                free_gate_nxt[i] = free_en[i];
            end
        end
        c24_nxt = x48_rise ? ~c24_r : c24_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_buf_r <= 1'b0;
            x48_r <= 1'b0;
            arm_cpu_r <= 1'b0;
            arm_per_r <= 1'b0;
            cpu_gate_r <= '0;
            mem_gate_r <= '0;
            per_gate_r <= '0;
            free_gate_r <= '0;
            c24_r <= 1'b0;
        end else begin
            mem_buf_r <= sync2_r[SY_BUF];
            x48_r <= sync2_r[SY_USB];
            arm_cpu_r <= arm_cpu_nxt;
            arm_per_r <= arm_per_nxt;
            cpu_gate_r <= cpu_gate_nxt;
            mem_gate_r <= mem_gate_nxt;
            per_gate_r <= per_gate_nxt;
            free_gate_r <= free_gate_nxt;
            c24_r <= c24_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // gates only move while their clock goes low, so an and gives no runt pulse
    genvar g;
    generate
        for (g = 0; g < CPU_GATED_N; g++) begin : g_cpu
            assign cpu_clk_gated[g] = cpu_clk && cpu_gate_r[g];
        end
        for (g = 0; g < MEM_GATED_N; g++) begin : g_mem
            assign mem_clk_gated[g] = mem_buf_r && mem_gate_r[g];
        end
        for (g = 1; g < PERIPH_GATED_N; g++) begin : g_per
            assign periph_clk_gated[g-1] = per_clk && per_gate_r[g];
        end
    endgenerate

    assign cpu_clk_free = cpu_clk && free_gate_r[FREE_CPU];
    assign mem_clk_free = mem_buf_r && free_gate_r[FREE_MEM];
    assign periph_clk_free = per_clk && free_gate_r[FREE_PERIPH];
    assign periph_clk_first = per_clk && per_gate_r[0];
    assign xtal_ref_out_a = running && sync2_r[SY_XTAL];
    assign xtal_ref_out_b = running && sync2_r[SY_XTAL];
    assign clk_24_out = c24_r;
    assign usb_48_out = x48_r;

    // strap pins stay released until the straps are caught
    assign clk_oe_n = outputs_tristate;
    assign periph_clk_first_oe_n = !running || outputs_tristate;
    assign periph_clk_free_oe_n = !running || outputs_tristate;
    assign xtal_ref_out_a_oe_n = !running || !mode_r || outputs_tristate;
    assign xtal_ref_out_b_oe_n = !running || outputs_tristate;
    assign clk_24_oe_n = !running || outputs_tristate;
    assign usb_48_oe_n = !running || outputs_tristate;

    assign active_code = sel_code;
    assign mode_latched = mode_r;
    assign straps_done = running;

endmodule
`default_nettype wire

// *** verif/scs_far_model.sv ***
// far-side model: chipset buffer source, crystal, 48 MHz source and strap resistors
`timescale 1ns/1ps
`default_nettype none
module scs_far_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic [4:0] strap_val,
    input wire logic [4:0] dev_out,
    input wire logic [4:0] dev_oe_n,
    output logic buffer_in,
    output logic xtal_ref_in,
    output logic usb_48_in,
    output logic [4:0] strap_pin
);
    // ----------------------------------------
    // sources
    // ----------------------------------------
    int cnt = 0;
    initial begin
        buffer_in = 1'b0;
        xtal_ref_in = 1'b0;
        usb_48_in = 1'b0;
    end
    // slow stretches the chipset half period to five cycles
    always @(negedge mclk) begin
        cnt <= cnt + 1;
        usb_48_in <= ~usb_48_in;
        if (cnt % 2 == 0) xtal_ref_in <= ~xtal_ref_in;
        if (cnt % (slow ? 5 : 2) == 0) buffer_in <= ~buffer_in;
    end
    // resistor level until the device takes the pin over
    assign strap_pin = (strap_val & dev_oe_n) | (dev_out & ~dev_oe_n);
endmodule
`default_nettype wire

// *** verif/scs_checker.sv ***
// concurrent checks on the clock select and gating top level ports
`timescale 1ns/1ps
`default_nettype none
module scs_checker
    import scs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_stop_n,
    input wire logic buffer_in,
    input wire logic [FREE_N-1:0] free_en,
    input wire logic outputs_tristate,
    input wire logic sw_sel_en,
    input wire logic periph_stop_n_in,
    input wire logic cpu_clk_free,
    input wire logic [CPU_GATED_N-1:0] cpu_clk_gated,
    input wire logic mem_clk_free,
    input wire logic [MEM_GATED_N-1:0] mem_clk_gated,
    input wire logic [PERIPH_GATED_N-2:0] periph_clk_gated,
    input wire logic clk_oe_n,
    input wire logic periph_clk_first,
    input wire logic periph_clk_first_oe_n,
    input wire logic periph_clk_free_oe_n,
    input wire logic xtal_ref_out_a_oe_n,
    input wire logic xtal_ref_out_b_oe_n,
    input wire logic clk_24_oe_n,
    input wire logic usb_48_oe_n,
    input wire logic [CODE_W-1:0] active_code,
    input wire logic mode_latched,
    input wire logic straps_done
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // saturating run and stop counters
    // ----------------------------------------
    logic [5:0] run_r, run_nxt, cs_r, cs_nxt, ps_r, ps_nxt;
    always_comb begin
        run_nxt = (straps_done && run_r != 6'h3f) ? run_r + 6'h01 : run_r;
        cs_nxt = cpu_stop_n ? 6'h00 : ((cs_r == 6'h3f) ? cs_r : cs_r + 6'h01);
        ps_nxt = (periph_stop_n_in || mode_latched) ? 6'h00 : ((ps_r == 6'h3f) ? ps_r : ps_r + 6'h01);
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_r <= 6'h00;
            cs_r <= 6'h00;
            ps_r <= 6'h00;
        end else begin
            run_r <= run_nxt;
            cs_r <= cs_nxt;
            ps_r <= ps_nxt;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // 48 cycles covers sync, arming on the slowest peripheral rise and one processor fall
    property p_cpu_stop; cs_r >= 6'h30 |-> cpu_clk_gated == '0; endproperty
    a_cpu_stop: assert property (p_cpu_stop) else $error("gated processor clock active while stopped");
    property p_mem_stop; cs_r >= 6'h30 |-> mem_clk_gated == '0; endproperty
    a_mem_stop: assert property (p_mem_stop) else $error("gated memory clock active while stopped");
    property p_periph_stop; ps_r >= 6'h30 |-> periph_clk_first == 1'b0 && periph_clk_gated == '0; endproperty
    a_periph_stop: assert property (p_periph_stop) else $error("peripheral clock active while stopped");
    property p_cpu_free;
        run_r == 6'h3f && free_en[FREE_CPU] && !outputs_tristate |-> ##[1:8] $changed(cpu_clk_free);
    endproperty
    a_cpu_free: assert property (p_cpu_free) else $error("free processor clock stalled");
    property p_mem_copy;
        run_r == 6'h3f && free_en[FREE_MEM] && !outputs_tristate |-> mem_clk_free == $past(buffer_in, 3);
    endproperty
    a_mem_copy: assert property (p_mem_copy) else $error("free memory clock not a copy of buffer input");
    property p_code_hold;
        straps_done && $past(straps_done) && !sw_sel_en && !$past(sw_sel_en) |-> $stable(active_code);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("hardware code changed after latching");
    property p_ref_mode; (straps_done && !outputs_tristate) [*2] |-> xtal_ref_out_a_oe_n == !mode_latched; endproperty
    a_ref_mode: assert property (p_ref_mode) else $error("shared pin direction does not follow mode");
    property p_tristate;
        outputs_tristate [*2] |-> clk_oe_n && periph_clk_free_oe_n && usb_48_oe_n && clk_24_oe_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("output driven while tristated");
    property p_strap_phase;
        !straps_done |-> periph_clk_first_oe_n && xtal_ref_out_b_oe_n && clk_24_oe_n && usb_48_oe_n;
    endproperty
    a_strap_phase: assert property (p_strap_phase) else $error("strap pin driven before latching");
    c_cpu_stop: cover property (cs_r == 6'h30);
    c_periph_stop: cover property (ps_r == 6'h30);
    c_ref_out: cover property (straps_done && mode_latched);
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the clock select and gating top level
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scs_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, cpu_stop_n = 1'b1, outputs_tristate = 1'b0, sw_sel_en = 1'b0;
    logic slow = 1'b0, stop_drv = 1'b1, meas = 1'b0, mode_latched, straps_done;
    logic [CPU_GATED_N-1:0] cpu_en = '1;
    logic [MEM_GATED_N-1:0] mem_en = '1;
    logic [PERIPH_GATED_N-1:0] periph_en = '1;
    logic [FREE_N-1:0] free_en = '1;
    logic [CODE_W-1:0] sw_sel_code = 4'hf;
    logic [4:0] strap_val = 5'h0a;
    logic buffer_in, xtal_ref_in, usb_48_in, cpu_clk_free, mem_clk_free, clk_oe_n, periph_clk_first;
    logic periph_clk_first_oe_n, periph_clk_free, periph_clk_free_oe_n, xtal_ref_out_a, xtal_ref_out_a_oe_n;
    logic xtal_ref_out_b, xtal_ref_out_b_oe_n, clk_24_out, clk_24_oe_n, usb_48_out, usb_48_oe_n;
    logic [CPU_GATED_N-1:0] cpu_clk_gated;
    logic [MEM_GATED_N-1:0] mem_clk_gated;
    logic [PERIPH_GATED_N-2:0] periph_clk_gated;
    logic [CODE_W-1:0] active_code;
    logic [11:0] sig, sig_q;
    wire [4:0] strap_pin;
    wire periph_stop_n_in;
    int tg [12], p_rise, miscompares, cmp_count;
    // processor rate in 10 kHz units and peripheral divide, indexed by code
    int rate_tab [16] = '{12400, 12000, 11500, 11000, 10500, 8330, 8000, 7500,
                          10020, 9525, 8330, 8000, 9000, 7000, 6680, 6000};
    int div_tab [16] = '{3, 3, 3, 3, 3, 2, 2, 2, 3, 3, 3, 3, 3, 2, 2, 2};
    always #20 mclk = ~mclk;
    assign periph_stop_n_in = xtal_ref_out_a_oe_n ? stop_drv : xtal_ref_out_a;
    scs_far_model u_scs_far_model (.mclk, .slow, .strap_val, .buffer_in, .xtal_ref_in, .usb_48_in, .strap_pin,
        .dev_out({periph_clk_free, periph_clk_first, xtal_ref_out_b, clk_24_out, usb_48_out}),
        .dev_oe_n({periph_clk_free_oe_n, periph_clk_first_oe_n, xtal_ref_out_b_oe_n, clk_24_oe_n, usb_48_oe_n}));
    scs_top u_scs_top (.mclk, .rst, .cpu_stop_n, .buffer_in, .xtal_ref_in, .usb_48_in, .cpu_en, .mem_en,
        .periph_en, .free_en, .outputs_tristate, .sw_sel_en, .sw_sel_code, .freq_strap_3_in(strap_pin[3]),
        .freq_strap_2_in(strap_pin[2]), .freq_strap_1_in(strap_pin[1]), .freq_strap_0_in(strap_pin[0]),
        .mode_strap_in(strap_pin[4]), .periph_stop_n_in, .cpu_clk_free, .cpu_clk_gated, .mem_clk_free,
        .mem_clk_gated, .periph_clk_gated, .clk_oe_n, .periph_clk_first, .periph_clk_first_oe_n, .periph_clk_free,
        .periph_clk_free_oe_n, .xtal_ref_out_a, .xtal_ref_out_a_oe_n, .xtal_ref_out_b, .xtal_ref_out_b_oe_n,
        .clk_24_out, .clk_24_oe_n, .usb_48_out, .usb_48_oe_n, .active_code, .mode_latched, .straps_done);
    // ----------------------------------------
    // edge counting and compare tasks
    // ----------------------------------------
    assign sig = {mem_clk_free, usb_48_out, clk_24_out, xtal_ref_out_b, xtal_ref_out_a, mem_clk_gated[0],
                  periph_clk_gated[3], periph_clk_first, cpu_clk_gated[1], cpu_clk_gated[0], periph_clk_free,
                  cpu_clk_free};
    always @(posedge mclk) begin
        sig_q <= sig;
        if (meas) begin
            for (int i = 0; i < 12; i++) if (sig[i] !== sig_q[i]) tg[i] <= tg[i] + 1;
            if (sig[1] === 1'b1 && sig_q[1] === 1'b0) p_rise <= p_rise + 1;
        end else begin
            tg <= '{default: 0};
            p_rise <= 0;
        end
    end
    task automatic measure(input int n);
        meas = 1'b1;
        repeat (n) @(negedge mclk);
        meas = 1'b0;
    endtask
    task automatic chk_bits(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_near(input string nm, input int exp, input int got, input int tol);
        cmp_count++;
        if (got > exp + tol || got < exp - tol) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        for (int i = 0; i < 20 && straps_done !== 1'b1; i++) @(negedge mclk);
        chk_bits("straps done", 16'h0001, 16'(straps_done));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        do_reset();
        measure(100);
        chk_bits("strap code", 16'h000a, 16'(active_code));
        chk_bits("mode", 16'h0000, 16'(mode_latched));
        chk_near("ref b toggles", 50, tg[8], 2);
        chk_near("24 toggles", tg[10] / 2, tg[9], 2);
        $display("test straps done");
        sw_sel_en = 1'b1;
        for (int c = 15; c >= 0; c--) begin
            sw_sel_code = 4'(c);
            repeat (40) @(negedge mclk);
            chk_bits("code", 16'(c), 16'(active_code));
            measure(1000);
            chk_near("cpu toggles", rate_tab[c] / 20, tg[0], 2);
            chk_near("gated toggles", rate_tab[c] / 20, tg[2], 2);
            chk_near("periph rises", rate_tab[c] / (40 * div_tab[c]), p_rise, 2);
        end
        $display("test frequency table done");
        sw_sel_code = 4'hb;
        slow = 1'b1;
        cpu_stop_n = 1'b0;
        repeat (60) @(negedge mclk);
        measure(100);
        chk_bits("stopped cpu", 16'h0000, 16'(tg[2]) | 16'(cpu_clk_gated));
        chk_bits("stopped mem", 16'h0000, 16'(tg[6]) | 16'(mem_clk_gated));
        chk_near("free cpu", 40, tg[0], 2);
        chk_near("free mem", 20, tg[11], 2);
        cpu_stop_n = 1'b1;
        cpu_en = 3'b101;
        periph_en = 5'b11110;
        free_en = 3'b110;
        repeat (60) @(negedge mclk);
        measure(100);
        chk_near("free disabled", 0, tg[0], 0);
        chk_near("cpu restart", 40, tg[2], 2);
        chk_near("cpu disabled", 0, tg[3], 0);
        chk_near("periph disabled", 0, tg[4], 0);
        chk_near("periph gated", 2 * p_rise, tg[5], 2);
        chk_near("mem restart", 20, tg[6], 2);
        cpu_en = '1;
        periph_en = '1;
        free_en = '1;
        stop_drv = 1'b0;
        repeat (60) @(negedge mclk);
        measure(100);
        chk_bits("periph stopped", 16'h0000, 16'(tg[4] + tg[5]) | 16'({periph_clk_gated, periph_clk_first}));
        chk_near("periph free", 6, p_rise, 2);
        stop_drv = 1'b1;
        outputs_tristate = 1'b1;
        repeat (3) @(negedge mclk);
        chk_bits("tristate", 16'h0007, 16'({clk_oe_n, usb_48_oe_n, periph_clk_free_oe_n}));
        outputs_tristate = 1'b0;
        $display("test gating done");
        sw_sel_en = 1'b0;
        slow = 1'b0;
        strap_val = 5'h13;
        do_reset();
        repeat (3) @(negedge mclk);
        chk_bits("strap code 2", 16'h0003, 16'(active_code));
        chk_bits("ref a oe", 16'h0000, 16'({xtal_ref_out_a_oe_n, !mode_latched}));
        measure(100);
        chk_near("ref a toggles", 50, tg[7], 2);
        chk_near("cpu strap rate", 55, tg[0], 2);
        $display("test mode one done");
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end
endmodule
bind scs_top scs_checker u_scs_checker (.mclk, .rst, .cpu_stop_n, .buffer_in, .free_en, .outputs_tristate,
    .sw_sel_en, .periph_stop_n_in, .cpu_clk_free, .cpu_clk_gated, .mem_clk_free, .mem_clk_gated,
    .periph_clk_gated, .clk_oe_n, .periph_clk_first, .periph_clk_first_oe_n, .periph_clk_free_oe_n,
    .xtal_ref_out_a_oe_n, .xtal_ref_out_b_oe_n, .clk_24_oe_n, .usb_48_oe_n, .active_code, .mode_latched,
    .straps_done);
`default_nettype wire
